// ---- hw/trx_exec.sv ----
// execution logic for table read, rotate right without carry and set file
// Functional notes
// - plain read: latch byte, pointer unchanged
// - post-increment: latch byte, then pointer plus one
// - post-decrement: latch byte, then pointer minus one
// - pre-increment: pointer plus one, then latch byte
// - decode table read opcode, low bits select mode
// - pointer is 21 bits, byte addressed
// - pointer only holds, increments, decrements or takes the pointer load value
// - rotate takes file address, destination, bank bit
// - rotate destination 0 working register, 1 file
// - set file takes address and bank bit
// - set file writes all ones, flags unchanged
// - rotate right, bit 0 to 7, Z and N
// - bank bit 0 access bank, 1 uses bank register
// - watchdog clear zeroes counter, sets timeout and powerdown
`timescale 1ns/1ps
`default_nettype none
module trx_exec
  import trx_pkg::*;
#(
  parameter int PM_ADDR_W = 10
) (
  input wire logic ref_clk_i, // core clock, one instruction cycle per edge
  input wire logic rst_b_i, // async reset, active low
  input wire logic instr_valid_i, // instruction word present
  input wire logic [15:0] instr_i, // instruction word
  output logic busy_o, // second table-read cycle, hold next word
  input wire logic [20:0] ptr_load_i_val_i, // pointer load value
  input wire logic ptr_load_i, // pointer load strobe
  input wire logic [3:0] bank_load_val_i, // bank register load value
  input wire logic bank_load_i, // bank register load strobe
  input wire logic pm_wr_en_i, // program memory load strobe
  input wire logic [PM_ADDR_W-1:0] pm_wr_addr_i, // program memory load address
  input wire logic [7:0] pm_wr_data_i, // program memory load data
  output logic [11:0] file_addr_o, // data file address
  output logic file_rd_o, // data file read strobe
  input wire logic [7:0] file_rd_data_i, // data file read data, same cycle
  output logic file_wr_o, // data file write strobe
  output logic [7:0] file_wr_data_o, // data file write data
  output logic [20:0] table_pointer_o, // table pointer
  output logic [7:0] table_latch_o, // table latch
  output logic [7:0] working_register_o, // working register
  output logic [3:0] bank_select_register_o, // bank select register
  output logic zero_flag_o, // zero flag
  output logic neg_flag_o, // negative flag
  output logic timeout_flag_o, // timeout flag
  output logic powerdown_flag_o, // powerdown flag
  output logic [7:0] wdt_count_o, // watchdog counter
  output logic [6:0] wdt_post_o // watchdog postscaler
);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic logic match(input logic [15:0] w, input logic [15:0] m,
                                 input logic [15:0] c);
    match = (w & m) == c;
  endfunction

  function automatic logic [11:0] bank_addr(input logic a, input logic [7:0] f,
                                            input logic [3:0] bank);
    if (a) begin
      bank_addr = {bank, f};
    end else if (f < TRX_ACCESS_SPLIT) begin
      bank_addr = {4'h0, f};
    end else begin
      bank_addr = {TRX_ACCESS_HI_BANK, f};
    end
  endfunction

  trx_state_t state_q, state_d;
  logic [20:0] ptr_q, ptr_d;
  logic [7:0] latch_q, latch_d;
  logic [7:0] work_q, work_d;
  logic [3:0] bank_q, bank_d;
  logic z_q, z_d, n_q, n_d;
  logic to_q, to_d, pwrdn_q, pwrdn_d;
  logic [7:0] wdt_q, wdt_d;
  logic [6:0] post_q, post_d;
  logic [1:0] mode_q, mode_d;
  logic [20:0] pm_addr;
  logic pm_rd;
  logic [7:0] pm_data;
  logic is_tbl, is_rrn, is_ones, is_wdt;
  logic [7:0] rot;

  // instruction classes, all dropped while the second table cycle runs
  always_comb begin
    is_tbl = instr_valid_i && !busy_o && match(instr_i, TRX_TBL_MASK, TRX_TBL_CODE);
    is_rrn = instr_valid_i && !busy_o && match(instr_i, TRX_RRN_MASK, TRX_RRN_CODE);
    is_ones = instr_valid_i && !busy_o && match(instr_i, TRX_ONES_MASK, TRX_ONES_CODE);
    is_wdt = instr_valid_i && !busy_o && (instr_i == TRX_WDT_CODE);
  end

  // busy marks the second table-read cycle
  assign busy_o = (state_q == TRX_TBL2);

  // ---------------------------------------------------------------
  // program memory
  // ---------------------------------------------------------------
  // pre-increment reads at the bumped address, other modes at the pointer
  always_comb begin
    pm_rd = is_tbl;
    pm_addr = (instr_i[1:0] == TRX_MODE_PREINC) ? 21'(ptr_q + 21'h1) : ptr_q;
  end

  trx_prog_mem #(.ADDR_W(PM_ADDR_W), .DATA_W(8)) u_pm (
    .ref_clk_i(ref_clk_i),
    .rd_addr_i(pm_addr[PM_ADDR_W-1:0]),
    .rd_en_i(pm_rd),
    .wr_en_i(pm_wr_en_i),
    .wr_addr_i(pm_wr_addr_i),
    .wr_data_i(pm_wr_data_i),
    .rd_data_o(pm_data)
  );

  // ---------------------------------------------------------------
  // data file access
  // ---------------------------------------------------------------
  // rotate reads, and with destination 1 also writes, in one cycle; set file only writes
  always_comb begin
    rot = {file_rd_data_i[0], file_rd_data_i[7:1]};
    file_addr_o = bank_addr(instr_i[TRX_A_BIT], instr_i[7:0], bank_q);
    file_rd_o = is_rrn;
    file_wr_o = is_ones || (is_rrn && instr_i[TRX_D_BIT]);
    file_wr_data_o = is_ones ? TRX_ALL_ONES : rot;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // defaults hold every register except the bank register and the pointer, which take a strobed load; the watchdog free-runs
  always_comb begin
    state_d = state_q;
    ptr_d = ptr_q;
    latch_d = latch_q;
    work_d = work_q;
    bank_d = bank_load_i ? bank_load_val_i : bank_q;
    z_d = z_q;
    n_d = n_q;
    to_d = to_q;
    pwrdn_d = pwrdn_q;
    wdt_d = 8'(wdt_q + 8'h1);
    post_d = post_q;
    mode_d = mode_q;
    if (wdt_q == 8'hFF) begin
      post_d = 7'(post_q + 7'h1);
    end
    if (ptr_load_i) begin
      ptr_d = ptr_load_i_val_i;
    end
    unique case (state_q)
      TRX_IDLE: begin
        if (is_tbl) begin
          state_d = TRX_TBL2;
          mode_d = instr_i[1:0];
          unique case (instr_i[1:0])
            TRX_MODE_PLAIN: ptr_d = ptr_q;
            TRX_MODE_POSTINC: ptr_d = 21'(ptr_q + 21'h1);
            TRX_MODE_POSTDEC: ptr_d = 21'(ptr_q - 21'h1);
            TRX_MODE_PREINC: ptr_d = 21'(ptr_q + 21'h1);
          endcase
        end
        if (is_rrn) begin
          z_d = (rot == 8'h00);
          n_d = rot[7];
          if (!instr_i[TRX_D_BIT]) begin
            work_d = rot;
          end
        end
        if (is_wdt) begin
          wdt_d = 8'h00;
          post_d = 7'h00;
          to_d = 1'b1;
          pwrdn_d = 1'b1;
        end
      end
      TRX_TBL2: begin
        latch_d = pm_data;
        state_d = TRX_IDLE;
      end
      TRX_RMW: begin
        state_d = TRX_IDLE;
      end
      default: begin
        state_d = TRX_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // all state, asynchronous active-low reset
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= TRX_IDLE;
      ptr_q <= TRX_PTR_RST;
      latch_q <= TRX_LATCH_RST;
      work_q <= TRX_WORK_RST;
      bank_q <= TRX_BANK_RST;
      z_q <= 1'b0;
      n_q <= 1'b0;
      to_q <= 1'b1;
      pwrdn_q <= 1'b1;
      wdt_q <= 8'h00;
      post_q <= 7'h00;
      mode_q <= TRX_MODE_PLAIN;
    end else begin
      state_q <= state_d;
      ptr_q <= ptr_d;
      latch_q <= latch_d;
      work_q <= work_d;
      bank_q <= bank_d;
      z_q <= z_d;
      n_q <= n_d;
      to_q <= to_d;
      pwrdn_q <= pwrdn_d;
      wdt_q <= wdt_d;
      post_q <= post_d;
      mode_q <= mode_d;
    end
  end

  // outputs straight from the registers
  assign table_pointer_o = ptr_q;
  assign table_latch_o = latch_q;
  assign working_register_o = work_q;
  assign bank_select_register_o = bank_q;
  assign zero_flag_o = z_q;
  assign neg_flag_o = n_q;
  assign timeout_flag_o = to_q;
  assign powerdown_flag_o = pwrdn_q;
  assign wdt_count_o = wdt_q;
  assign wdt_post_o = post_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  tbl_two_cycle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    is_tbl |=> busy_o ##1 !busy_o) else $error("table read not two cycles");
  tbl_postinc_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (is_tbl && instr_i[1:0] == 2'h1 && !ptr_load_i) |=> ptr_q == $past(ptr_q) + 21'h1)
    else $error("post increment wrong");
  tbl_postdec_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (is_tbl && instr_i[1:0] == 2'h2 && !ptr_load_i) |=> ptr_q == $past(ptr_q) - 21'h1)
    else $error("post decrement wrong");
  tbl_plain_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (is_tbl && instr_i[1:0] == 2'h0 && !ptr_load_i) |=> $stable(ptr_q))
    else $error("plain read moved pointer");
  tbl_flags_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    is_tbl |=> $stable(z_q) && $stable(n_q) ##1 $stable(z_q))
    else $error("table read changed flags");
  rot_value_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (is_rrn && instr_i[TRX_D_BIT]) |-> file_wr_o
      && file_wr_data_o == {file_rd_data_i[0], file_rd_data_i[7:1]})
    else $error("rotate write wrong");
  rot_work_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (is_rrn && !instr_i[TRX_D_BIT]) |-> !file_wr_o ##1 work_q == $past(rot)
      && z_q == ($past(rot) == 8'h00)) else $error("rotate result wrong");
  ones_write_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    is_ones |-> file_wr_o && file_wr_data_o == 8'hFF ##1 $stable(z_q) && $stable(n_q))
    else $error("set file wrong");
  bank_access_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    ((is_rrn || is_ones) && !instr_i[TRX_A_BIT] && instr_i[7] == 1'b0)
      |-> file_addr_o[11:8] == 4'h0) else $error("access bank wrong");
  wdt_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    is_wdt |=> wdt_q == 8'h00 && post_q == 7'h00 && to_q && pwrdn_q)
    else $error("watchdog clear wrong");
  // pre-increment bumps the pointer at the decode edge
  tbl_preinc_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (is_tbl && instr_i[1:0] == 2'h3 && !ptr_load_i) |=> ptr_q == $past(ptr_q) + 21'h1)
    else $error("pre increment wrong");
  // pointer holds through the second table cycle
  tbl_ptr_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (busy_o && !ptr_load_i) |=> $stable(ptr_q))
    else $error("pointer moved while busy");
  // words offered while busy touch no file register
  busy_refuse_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    busy_o |-> !file_wr_o && !file_rd_o) else $error("file access while busy");
  // latch only changes at the end of the second cycle
  latch_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !busy_o |=> $stable(latch_q)) else $error("latch changed outside table read");
  // set file leaves the working register alone
  ones_work_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    is_ones |=> $stable(work_q)) else $error("set file changed working register");
  // rotate to file leaves the working register alone
  rot_file_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (is_rrn && instr_i[TRX_D_BIT]) |=> $stable(work_q))
    else $error("rotate to file changed working register");
  // access bank upper half maps to the top bank
  bank_high_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    ((is_rrn || is_ones) && !instr_i[TRX_A_BIT] && instr_i[7])
      |-> file_addr_o[11:8] == 4'hF) else $error("access bank high wrong");
  // bank bit set takes the bank from the bank register
  bank_reg_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    ((is_rrn || is_ones) && instr_i[TRX_A_BIT])
      |-> file_addr_o == {bank_q, instr_i[7:0]}) else $error("banked address wrong");
  // negative is the old bit 0, zero only for a zero operand
  rot_flags_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    is_rrn |=> n_q == $past(file_rd_data_i[0]) && z_q == ($past(file_rd_data_i) == 8'h00))
    else $error("rotate flags wrong");
  // watchdog counts every cycle unless cleared
  wdt_count_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !is_wdt |=> wdt_q == 8'($past(wdt_q) + 8'h1))
    else $error("watchdog count wrong");
endmodule
`default_nettype wire

// ---- hw/trx_pkg.sv ----
// package of constants for the table-read, rotate and set-file execution block
package trx_pkg;
  localparam int TRX_PTR_W = 21;
  localparam int TRX_DATA_W = 8;
  localparam int TRX_INSTR_W = 16;
  localparam int TRX_FADDR_W = 8;
  localparam int TRX_BANK_W = 4;
  localparam int TRX_DADDR_W = 12;
  localparam int TRX_WDT_W = 8;
  localparam int TRX_POST_W = 7;
  // opcode patterns and masks
  localparam logic [15:0] TRX_TBL_MASK = 16'hFFFC;
  localparam logic [15:0] TRX_TBL_CODE = 16'h0008;
  localparam logic [15:0] TRX_RRN_MASK = 16'hFC00;
  localparam logic [15:0] TRX_RRN_CODE = 16'h4000;
  localparam logic [15:0] TRX_ONES_MASK = 16'hFE00;
  localparam logic [15:0] TRX_ONES_CODE = 16'h6800;
  localparam logic [15:0] TRX_WDT_CODE = 16'h0004;
  // operand field positions
  localparam int TRX_D_BIT = 9;
  localparam int TRX_A_BIT = 8;
  // table read modes
  localparam logic [1:0] TRX_MODE_PLAIN = 2'h0;
  localparam logic [1:0] TRX_MODE_POSTINC = 2'h1;
  localparam logic [1:0] TRX_MODE_POSTDEC = 2'h2;
  localparam logic [1:0] TRX_MODE_PREINC = 2'h3;
  // access bank split: low addresses map to bank 0, high ones to the top bank
  localparam logic [7:0] TRX_ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] TRX_ACCESS_HI_BANK = 4'hF;
  localparam logic [7:0] TRX_ALL_ONES = 8'hFF;
  // reset values
  localparam logic [20:0] TRX_PTR_RST = 21'h000000;
  localparam logic [7:0] TRX_LATCH_RST = 8'h00;
  localparam logic [7:0] TRX_WORK_RST = 8'h00;
  localparam logic [3:0] TRX_BANK_RST = 4'h0;
  typedef enum logic [2:0] {
    TRX_IDLE = 3'b001,
    TRX_TBL2 = 3'b010,
    TRX_RMW = 3'b100
  } trx_state_t;
endpackage

// ---- hw/trx_prog_mem.sv ----
// byte-wide program memory model with registered read data
`timescale 1ns/1ps
`default_nettype none
module trx_prog_mem #(
  parameter int ADDR_W = 10,
  parameter int DATA_W = 8
) (
  input wire logic ref_clk_i, // core clock
  input wire logic [ADDR_W-1:0] rd_addr_i, // byte address
  input wire logic rd_en_i, // read strobe
  input wire logic wr_en_i, // load strobe
  input wire logic [ADDR_W-1:0] wr_addr_i, // load address
  input wire logic [DATA_W-1:0] wr_data_i, // load data
  output logic [DATA_W-1:0] rd_data_o // registered read data
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] rd_data_q;

  // synchronous write and registered read
  always_ff @(posedge ref_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    if (rd_en_i) begin
      rd_data_q <= mem[rd_addr_i];
    end
  end

  assign rd_data_o = rd_data_q;
endmodule
`default_nettype wire

// ---- testbench/trx_file_model.sv ----
// data file register model facing the execution block
`timescale 1ns/1ps
`default_nettype none
module trx_file_model (
  input wire logic ref_clk_i, // core clock
  input wire logic [11:0] file_addr_i, // data file address
  input wire logic file_rd_i, // read strobe
  input wire logic file_wr_i, // write strobe
  input wire logic [7:0] file_wr_data_i, // write data
  output logic [7:0] file_rd_data_o // read data, same cycle
);
  logic [7:0] mem [4096];
  logic [7:0] last_q = 8'h00;
  // preset contents, one location in each 256-byte bank reads as zero
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = i[7:0] ^ 8'h5A;
    end
  end
  // data only while read, otherwise the inverse of the last byte
  assign file_rd_data_o = (file_rd_i === 1'b1) ? mem[file_addr_i] : ~last_q;
  // write lands at the edge that ends the cycle
  always @(posedge ref_clk_i) begin
    if (file_rd_i === 1'b1) begin
      last_q <= mem[file_addr_i];
    end
    if (file_wr_i === 1'b1) begin
      mem[file_addr_i] <= file_wr_data_i;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// self-checking bench for the table-read, rotate and set-file block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import trx_pkg::*;
  typedef struct {string nm; logic [31:0] v;} trx_note_t;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic instr_valid_i = 1'b0;
  logic ptr_load_i = 1'b0;
  logic bank_load_i = 1'b0;
  logic pm_wr_en_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic [20:0] ptr_load_i_val_i = 21'h000000;
  logic [3:0] bank_load_val_i = 4'h0;
  logic [9:0] pm_wr_addr_i = 10'h000;
  logic [7:0] pm_wr_data_i = 8'h00;
  logic busy_o, file_rd_o, file_wr_o, zero_flag_o, neg_flag_o, timeout_flag_o, powerdown_flag_o;
  logic [11:0] file_addr_o;
  logic [7:0] file_rd_data_i, file_wr_data_o, table_latch_o, working_register_o, wdt_count_o;
  logic [20:0] table_pointer_o;
  logic [3:0] bank_select_register_o;
  logic [6:0] wdt_post_o;
  logic [7:0] pm [1024];
  logic [7:0] sh [4096];
  logic [20:0] e_p;
  logic [7:0] e_w;
  logic [3:0] e_b = 4'h0;
  logic e_z = 1'b0;
  logic e_n = 1'b0;
  logic dfr = 1'b0;
  logic pbusy = 1'b0;
  logic [31:0] lf = 32'h00000FCE;
  int num_errors = 0;
  int checked = 0;
  trx_note_t q[$];

  trx_exec #(.PM_ADDR_W(10)) i_dut (.ref_clk_i, .rst_b_i, .instr_valid_i, .instr_i, .busy_o,
    .ptr_load_i_val_i, .ptr_load_i, .bank_load_val_i, .bank_load_i, .pm_wr_en_i, .pm_wr_addr_i,
    .pm_wr_data_i, .file_addr_o, .file_rd_o, .file_rd_data_i, .file_wr_o, .file_wr_data_o,
    .table_pointer_o, .table_latch_o, .working_register_o, .bank_select_register_o,
    .zero_flag_o, .neg_flag_o, .timeout_flag_o, .powerdown_flag_o, .wdt_count_o, .wdt_post_o);
  trx_file_model i_file (.ref_clk_i, .file_addr_i(file_addr_o), .file_rd_i(file_rd_o),
    .file_wr_i(file_wr_o), .file_wr_data_i(file_wr_data_o), .file_rd_data_o(file_rd_data_i));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (e !== g) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic pop(input logic [31:0] g);
    trx_note_t n;
    if (q.size() == 0) begin
      chk("note queue", 32'h0, 32'h1);
    end else begin
      n = q.pop_front();
      chk(n.nm, n.v, g);
    end
  endtask
  // drive one cycle of inputs just after the edge
  task automatic step(input logic v, input logic [15:0] w, input logic pl, input logic bl);
    @(posedge ref_clk_i);
    #2;
    instr_valid_i = v;
    instr_i = w;
    ptr_load_i = pl;
    bank_load_i = bl;
  endtask
  // load pointer, read table, offer a word during the busy cycle
  task automatic tbl(input logic [1:0] m, input logic [20:0] p);
    ptr_load_i_val_i = p;
    step(1'b0, 16'h0000, 1'b1, 1'b0);
    e_p = (m == TRX_MODE_PREINC) ? p + 21'h1 : p;
    q.push_back('{"table read", {1'b0, e_n, e_z, e_p, pm[e_p[9:0]]}});
    if (m == TRX_MODE_POSTINC) e_p = e_p + 21'h1;
    if (m == TRX_MODE_POSTDEC) e_p = e_p - 21'h1;
    q[$].v[28:8] = e_p;
    step(1'b1, TRX_TBL_CODE | {14'h0, m}, 1'b0, 1'b0);
    step(1'b1, 16'h6955, 1'b0, 1'b0);
    step(1'b0, 16'h0000, 1'b0, 1'b0);
  endtask
  // k 0 rotate to working register, 1 rotate to file, 2 set file
  task automatic fop(input logic [1:0] k, input logic a, input logic [7:0] f);
    logic [11:0] ad;
    logic [7:0] r;
    ad = a ? {e_b, f} : (f >= 8'h80 ? {4'hF, f} : {4'h0, f});
    r = (k == 2'h2) ? 8'hFF : {sh[ad][0], sh[ad][7:1]};
    if (k != 2'h0) begin
      sh[ad] = r;
      q.push_back('{"file write", {12'h0, ad, r}});
    end
    if (k == 2'h0) e_w = r;
    if (k != 2'h2) begin
      e_z = (r == 8'h00);
      e_n = r[7];
    end
    q.push_back('{"work reg and flags", {22'h0, e_n, e_z, e_w}});
    step(1'b1, (k == 2'h2) ? {7'h34, a, f} : {6'h10, k[0], a, f}, 1'b0, 1'b0);
  endtask

  // ---------------------------------------------------------------
  // clock, watcher, hang guard
  // ---------------------------------------------------------------
  initial begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  // results in order: deferred register check, table latch, file write
  always @(negedge ref_clk_i) begin
    if (rst_b_i === 1'b1) begin
      if (dfr) pop({22'h0, neg_flag_o, zero_flag_o, working_register_o});
      if (pbusy && busy_o === 1'b0) pop({1'b0, neg_flag_o, zero_flag_o, table_pointer_o,
        table_latch_o});
      if (file_wr_o === 1'b1) pop({12'h0, file_addr_o, file_wr_data_o});
      dfr = (file_rd_o === 1'b1) || (file_wr_o === 1'b1);
      pbusy = (busy_o === 1'b1);
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    num_errors++;
    close_out();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    e_p = TRX_PTR_RST;
    e_w = TRX_WORK_RST;
    for (int i = 0; i < 4096; i++) sh[i] = i[7:0] ^ 8'h5A;
    repeat (12) @(posedge ref_clk_i);
    #2;
    rst_b_i = 1'b1;
    chk("reset pointer", {11'h0, TRX_PTR_RST}, {11'h0, table_pointer_o});
    chk("reset regs", {16'h0, 8'h00, 4'h0, 4'h3}, {16'h0, working_register_o,
      bank_select_register_o, zero_flag_o, neg_flag_o, timeout_flag_o, powerdown_flag_o});
    for (int i = 0; i < 1024; i++) begin
      @(posedge ref_clk_i);
      #2;
      lf = nxt(lf);
      pm_wr_en_i = 1'b1;
      pm_wr_addr_i = i[9:0];
      pm_wr_data_i = lf[7:0];
      pm[i] = lf[7:0];
    end
    @(posedge ref_clk_i);
    #2;
    pm_wr_en_i = 1'b0;
    for (int m = 0; m < 4; m++) begin
      lf = nxt(lf);
      tbl(m[1:0], lf[20:0]);
      tbl(m[1:0], 21'h000000);
      tbl(m[1:0], 21'h1FFFFF);
    end
    step(1'b1, TRX_WDT_CODE, 1'b0, 1'b0);
    step(1'b0, 16'h0000, 1'b0, 1'b0);
    @(negedge ref_clk_i);
    chk("watchdog clear", {15'h0, 2'h3, 8'h00, 7'h00}, {15'h0, timeout_flag_o, powerdown_flag_o,
      wdt_count_o, wdt_post_o});
    fop(2'h0, 1'b0, 8'h5A);
    for (int i = 0; i < 80; i++) begin
      lf = nxt(lf);
      if (lf[12]) begin
        bank_load_val_i = lf[11:8];
        e_b = lf[11:8];
        step(1'b0, 16'h0000, 1'b0, 1'b1);
      end
      fop((lf[1:0] == 2'h3) ? 2'h2 : lf[1:0], lf[2], lf[23:16]);
      if (lf[3]) tbl(lf[5:4], lf[30:10]);
    end
    step(1'b0, 16'h0000, 1'b0, 1'b0);
    repeat (3) @(posedge ref_clk_i);
    chk("notes left", 32'h0, q.size());
    close_out();
  end
endmodule
`default_nettype wire
